// ### src/spom_pkg.sv
// Shared constants, types and helpers of the strobe pulse output block
package spom_pkg;
    // Time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DIV_W = 7;
    localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_CYCLES - 1);

    // Microsecond settings
    localparam int US_W = 20;
    localparam logic [US_W-1:0] US_MIN = 20'h00001;
    localparam logic [US_W-1:0] US_MAX = 20'hf4240;
    localparam logic [US_W-1:0] DELAY_RST = 20'h00001;
    localparam logic [US_W-1:0] WIDTH_RST = 20'h00001;

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_A_DELAY = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_A_WIDTH = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_B_DELAY = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_B_WIDTH = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_LINE_CFG = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;

    // Field positions
    localparam int CTRL_A_EN_BIT = 0;
    localparam int CTRL_A_REF_BIT = 1;
    localparam int CTRL_B_EN_BIT = 2;
    localparam int CTRL_B_REF_BIT = 3;
    localparam int LINE_A_SRC_LSB = 0;
    localparam int LINE_A_LVL_BIT = 3;
    localparam int LINE_B_SRC_LSB = 4;
    localparam int LINE_B_LVL_BIT = 7;
    localparam int SRC_W = 3;

    // Reset values of loose control bits
    localparam logic ENABLE_RST = 1'b0;
    localparam logic REF_RST = 1'b0;
    localparam logic LEVEL_RST = 1'b1;

    typedef enum logic [SRC_W-1:0] {SRC_NONE, SRC_TRIGGER, SRC_PULSE_GEN, SRC_FLASH_A, SRC_FLASH_B} spom_src_e;
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_PULSE} spom_flash_e;

    // Keeps a written microsecond value inside 1..1000000
    function automatic logic [US_W-1:0] spom_clamp_us(input logic [31:0] v);
        if (v < 32'(US_MIN)) begin
            return US_MIN;
        end else if (v > 32'(US_MAX)) begin
            return US_MAX;
        end
        return v[US_W-1:0];
    endfunction : spom_clamp_us
endpackage : spom_pkg

// ### src/spom_flash.sv
// One strobe pulse generator: delay then width, in microsecond ticks
module spom_flash (
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic i_tick_us, // One-cycle pulse each microsecond
    input wire logic i_enable, // Strobe switched on
    input wire logic i_ref_select, // 0 exposure start, 1 readout start
    input wire logic i_exposure_begin_event, // Exposure start pulse
    input wire logic i_readout_begin_event, // Readout start pulse
    input wire logic [spom_pkg::US_W-1:0] i_delay_us, // Delay setting
    input wire logic [spom_pkg::US_W-1:0] i_width_us, // Width setting
    output logic o_active, // Strobe pulse active
    output logic o_waiting // Delay in progress
);
    import spom_pkg::*;

    spom_flash_e state;
    logic [US_W-1:0] cnt;
    logic [US_W-1:0] cnt_inc;
    logic ref_event;

    assign ref_event = i_ref_select ? i_readout_begin_event : i_exposure_begin_event;
    assign cnt_inc = cnt + 1'b1;
    assign o_active = (state == ST_PULSE);
    assign o_waiting = (state == ST_DELAY);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            cnt <= '0;
        end else if (!i_enable) begin
            state <= ST_IDLE;
            cnt <= '0;
        end else if (ref_event) begin
            state <= ST_DELAY;
            cnt <= '0;
        end else begin
            case (state)
                ST_DELAY: begin
                    if (i_tick_us) begin
                        if (cnt_inc >= i_delay_us) begin
                            state <= ST_PULSE;
                            cnt <= '0;
                        end else begin
                            cnt <= cnt_inc;
                        end
                    end
                end
                ST_PULSE: begin
                    if (i_tick_us) begin
                        if (cnt_inc >= i_width_us) begin
                            state <= ST_IDLE;
                            cnt <= '0;
                        end else begin
                            cnt <= cnt_inc;
                        end
                    end
                end
                ST_IDLE: begin
                    cnt <= '0;
                end
                default: begin
                    state <= ST_IDLE;
                    cnt <= '0;
                end
            endcase
        end
    end

    a_off_stays_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_enable |=> !o_active && !o_waiting)
        else $error("disabled strobe not idle");
    a_event_restarts: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_enable && ref_event) |=> o_waiting && cnt == '0)
        else $error("reference event did not restart the delay");
    a_delay_ends: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_enable && !ref_event && o_waiting && i_tick_us && cnt_inc >= i_delay_us) |=> o_active)
        else $error("pulse did not start after the delay");
    a_width_ends: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_enable && !ref_event && o_active && i_tick_us && cnt_inc >= i_width_us) |=> !o_active)
        else $error("pulse did not end after the width");
    a_pulse_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_active && i_enable && !ref_event && !i_tick_us) |=> o_active)
        else $error("pulse ended between ticks");
endmodule : spom_flash

// ### src/spom_top.sv
// Strobe pulse generators and output line routing with an Avalon-MM register slave
module spom_top (
    input wire logic I_CLK, // 100 MHz clock
    input wire logic I_RST_N, // Asynchronous reset, active low
    input wire logic [spom_pkg::ADDR_W-1:0] I_AVS_ADDRESS, // Byte address
    input wire logic I_AVS_READ, // Read request
    input wire logic I_AVS_WRITE, // Write request
    input wire logic [31:0] I_AVS_WRITEDATA, // Write data
    input wire logic [3:0] I_AVS_BYTEENABLE, // Byte lanes
    output logic [31:0] O_AVS_READDATA, // Read data
    output logic O_AVS_WAITREQUEST, // Stall, low for the answering cycle
    input wire logic I_EXPOSURE_BEGIN_EVENT, // Exposure start pulse
    input wire logic I_READOUT_BEGIN_EVENT, // Readout start pulse
    input wire logic I_TRIGGER, // Trigger signal, active high
    input wire logic I_INTERNAL_PULSE_SOURCE, // Pulse generator signal, active high
    output logic O_OUTPUT_LINE_A, // Output line A pin
    output logic O_OUTPUT_LINE_B // Output line B pin
);
    import spom_pkg::*;

    logic [DIV_W-1:0] div_cnt;
    logic tick_us;
    logic flash_a_enable;
    logic flash_a_ref_select;
    logic flash_b_enable;
    logic flash_b_ref_select;
    logic [US_W-1:0] flash_a_delay_us;
    logic [US_W-1:0] flash_a_width_us;
    logic [US_W-1:0] flash_b_delay_us;
    logic [US_W-1:0] flash_b_width_us;
    logic [SRC_W-1:0] line_source_select_a;
    logic [SRC_W-1:0] line_source_select_b;
    logic line_active_level_a;
    logic line_active_level_b;
    logic flash_a_active;
    logic flash_a_waiting;
    logic flash_b_active;
    logic flash_b_waiting;
    logic line_sig_a;
    logic line_sig_b;
    logic [31:0] wmask;
    logic [31:0] next_readdata;
    logic do_write;

    // Microsecond tick
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            div_cnt <= '0;
            tick_us <= 1'b0;
        end else if (div_cnt == TICK_LAST) begin
            div_cnt <= '0;
            tick_us <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            tick_us <= 1'b0;
        end
    end

    // Bus handshake: answer one cycle after the request is seen
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= '0;
        end else if (O_AVS_WAITREQUEST && (I_AVS_READ || I_AVS_WRITE)) begin
            O_AVS_WAITREQUEST <= 1'b0;
            O_AVS_READDATA <= I_AVS_READ ? next_readdata : 32'h00000000;
        end else begin
            O_AVS_WAITREQUEST <= 1'b1;
        end
    end

    assign do_write = I_AVS_WRITE && !O_AVS_WAITREQUEST;

    generate
        for (genvar g = 0; g < 4; g++) begin : g_lane
            assign wmask[g*8 +: 8] = {8{I_AVS_BYTEENABLE[g]}};
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction : merge

    function automatic logic [31:0] widen(input logic [US_W-1:0] v);
        return {{(32 - US_W){1'b0}}, v};
    endfunction : widen

    // Control bits
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            flash_a_enable <= ENABLE_RST;
            flash_a_ref_select <= REF_RST;
            flash_b_enable <= ENABLE_RST;
            flash_b_ref_select <= REF_RST;
        end else if (do_write && I_AVS_ADDRESS == OFF_CTRL && I_AVS_BYTEENABLE[0]) begin
            flash_a_enable <= I_AVS_WRITEDATA[CTRL_A_EN_BIT];
            flash_a_ref_select <= I_AVS_WRITEDATA[CTRL_A_REF_BIT];
            flash_b_enable <= I_AVS_WRITEDATA[CTRL_B_EN_BIT];
            flash_b_ref_select <= I_AVS_WRITEDATA[CTRL_B_REF_BIT];
        end
    end

    // Microsecond settings, clamped into range
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            flash_a_delay_us <= DELAY_RST;
            flash_a_width_us <= WIDTH_RST;
            flash_b_delay_us <= DELAY_RST;
            flash_b_width_us <= WIDTH_RST;
        end else if (do_write) begin
            case (I_AVS_ADDRESS)
                OFF_A_DELAY: begin
                    flash_a_delay_us <= spom_clamp_us(merge(widen(flash_a_delay_us), I_AVS_WRITEDATA, wmask));
                end
                OFF_A_WIDTH: begin
                    flash_a_width_us <= spom_clamp_us(merge(widen(flash_a_width_us), I_AVS_WRITEDATA, wmask));
                end
                OFF_B_DELAY: begin
                    flash_b_delay_us <= spom_clamp_us(merge(widen(flash_b_delay_us), I_AVS_WRITEDATA, wmask));
                end
                OFF_B_WIDTH: begin
                    flash_b_width_us <= spom_clamp_us(merge(widen(flash_b_width_us), I_AVS_WRITEDATA, wmask));
                end
                default: begin
                end
            endcase
        end
    end

    // Output line configuration
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            line_source_select_a <= SRC_NONE;
            line_source_select_b <= SRC_NONE;
            line_active_level_a <= LEVEL_RST;
            line_active_level_b <= LEVEL_RST;
        end else if (do_write && I_AVS_ADDRESS == OFF_LINE_CFG && I_AVS_BYTEENABLE[0]) begin
            line_source_select_a <= I_AVS_WRITEDATA[LINE_A_SRC_LSB +: SRC_W];
            line_active_level_a <= I_AVS_WRITEDATA[LINE_A_LVL_BIT];
            line_source_select_b <= I_AVS_WRITEDATA[LINE_B_SRC_LSB +: SRC_W];
            line_active_level_b <= I_AVS_WRITEDATA[LINE_B_LVL_BIT];
        end
    end

    // Read-back; unmapped addresses read zero
    always_comb begin
        next_readdata = 32'h00000000;
        case (I_AVS_ADDRESS)
            OFF_CTRL: begin
                next_readdata[CTRL_A_EN_BIT] = flash_a_enable;
                next_readdata[CTRL_A_REF_BIT] = flash_a_ref_select;
                next_readdata[CTRL_B_EN_BIT] = flash_b_enable;
                next_readdata[CTRL_B_REF_BIT] = flash_b_ref_select;
            end
            OFF_A_DELAY: next_readdata = widen(flash_a_delay_us);
            OFF_A_WIDTH: next_readdata = widen(flash_a_width_us);
            OFF_B_DELAY: next_readdata = widen(flash_b_delay_us);
            OFF_B_WIDTH: next_readdata = widen(flash_b_width_us);
            OFF_LINE_CFG: begin
                next_readdata[LINE_A_SRC_LSB +: SRC_W] = line_source_select_a;
                next_readdata[LINE_A_LVL_BIT] = line_active_level_a;
                next_readdata[LINE_B_SRC_LSB +: SRC_W] = line_source_select_b;
                next_readdata[LINE_B_LVL_BIT] = line_active_level_b;
            end
            OFF_STATUS: begin
                next_readdata[5:0] = {O_OUTPUT_LINE_B, O_OUTPUT_LINE_A, flash_b_waiting,
                                      flash_a_waiting, flash_b_active, flash_a_active};
            end
            default: begin
                next_readdata = 32'h00000000;
            end
        endcase
    end

    spom_flash u_flash_a (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_tick_us(tick_us),
        .i_enable(flash_a_enable),
        .i_ref_select(flash_a_ref_select),
        .i_exposure_begin_event(I_EXPOSURE_BEGIN_EVENT),
        .i_readout_begin_event(I_READOUT_BEGIN_EVENT),
        .i_delay_us(flash_a_delay_us),
        .i_width_us(flash_a_width_us),
        .o_active(flash_a_active),
        .o_waiting(flash_a_waiting)
    );

    spom_flash u_flash_b (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_tick_us(tick_us),
        .i_enable(flash_b_enable),
        .i_ref_select(flash_b_ref_select),
        .i_exposure_begin_event(I_EXPOSURE_BEGIN_EVENT),
        .i_readout_begin_event(I_READOUT_BEGIN_EVENT),
        .i_delay_us(flash_b_delay_us),
        .i_width_us(flash_b_width_us),
        .o_active(flash_b_active),
        .o_waiting(flash_b_waiting)
    );

    function automatic logic pick(input logic [SRC_W-1:0] sel, input logic trig, input logic pg,
                                  input logic fa, input logic fb);
        case (sel)
            SRC_TRIGGER: return trig;
            SRC_PULSE_GEN: return pg;
            SRC_FLASH_A: return fa;
            SRC_FLASH_B: return fb;
            default: return 1'b0;
        endcase
    endfunction : pick

    assign line_sig_a = pick(line_source_select_a, I_TRIGGER, I_INTERNAL_PULSE_SOURCE,
                             flash_a_active, flash_b_active);
    assign line_sig_b = pick(line_source_select_b, I_TRIGGER, I_INTERNAL_PULSE_SOURCE,
                             flash_a_active, flash_b_active);

    // Polarity applied at the pins; an idle source gives the inactive level
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_OUTPUT_LINE_A <= 1'b0;
            O_OUTPUT_LINE_B <= 1'b0;
        end else begin
            O_OUTPUT_LINE_A <= line_active_level_a ? line_sig_a : !line_sig_a;
            O_OUTPUT_LINE_B <= line_active_level_b ? line_sig_b : !line_sig_b;
        end
    end

    a_tick_period: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        tick_us |-> ##100 tick_us)
        else $error("microsecond tick period wrong");
    a_line_a_none: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        line_source_select_a == SRC_NONE |=> O_OUTPUT_LINE_A == !$past(line_active_level_a))
        else $error("line A not at inactive level with no source");
    a_line_a_flash: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        line_source_select_a == SRC_FLASH_A |=>
        O_OUTPUT_LINE_A == ($past(flash_a_active) ~^ $past(line_active_level_a)))
        else $error("line A does not follow strobe A");
    a_line_a_trig: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (line_source_select_a == SRC_TRIGGER && line_active_level_a) |=> O_OUTPUT_LINE_A == $past(I_TRIGGER))
        else $error("line A does not follow trigger");
    a_line_b_flash: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        line_source_select_b == SRC_FLASH_B |=>
        O_OUTPUT_LINE_B == ($past(flash_b_active) ~^ $past(line_active_level_b)))
        else $error("line B does not follow strobe B");
    a_delay_clamp: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (do_write && I_AVS_ADDRESS == OFF_A_DELAY && I_AVS_BYTEENABLE == 4'hf && I_AVS_WRITEDATA == 32'h0)
        |=> flash_a_delay_us == US_MIN)
        else $error("zero delay not clamped to one");
    a_bus_answer: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (O_AVS_WAITREQUEST && (I_AVS_READ || I_AVS_WRITE)) |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
        else $error("bus answer not one cycle");
endmodule : spom_top

// ### sim/spom_lamp.sv
// Lamp model on one output line: measures each flash in clock cycles
module spom_lamp (
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic i_arm, // Measure only while armed
    input wire logic i_active_high, // Polarity of the line
    input wire logic i_line, // Output line pin
    output logic o_done, // One cycle after a flash ends
    output logic [31:0] o_len // Length of the last flash in cycles
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] cnt;

    // Counts edges seen with the line lit, reports on the first dark edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 32'h0;
            o_done <= 1'b0;
            o_len <= 32'h0;
        end else begin
            o_done <= 1'b0;
            if (i_arm && (i_line === i_active_high)) begin
                cnt <= cnt + 32'h1;
            end else if (cnt != 32'h0) begin
                o_done <= 1'b1;
                o_len <= cnt;
                cnt <= 32'h0;
            end
        end
    end
endmodule : spom_lamp

// ### sim/tb_strobe_pulse_output_mux.sv
// Self-checking bench of the strobe pulse output block
module tb_strobe_pulse_output_mux;
    timeunit 1ns;
    timeprecision 100ps;
    import spom_pkg::*;
    logic I_CLK = 1'b0, I_RST_N = 1'b0, I_AVS_READ = 1'b0, I_AVS_WRITE = 1'b0, I_TRIGGER = 1'b0;
    logic I_EXPOSURE_BEGIN_EVENT = 1'b0, I_READOUT_BEGIN_EVENT = 1'b0, I_INTERNAL_PULSE_SOURCE = 1'b0;
    logic [7:0] I_AVS_ADDRESS = 8'h00;
    logic [3:0] I_AVS_BYTEENABLE = 4'hf;
    logic [31:0] I_AVS_WRITEDATA = 32'h0, O_AVS_READDATA, rd_got, len_a, len_b;
    logic [31:0] seed = 32'h00013f9d;
    logic O_AVS_WAITREQUEST, O_OUTPUT_LINE_A, O_OUTPUT_LINE_B, done_a, done_b, lamp_arm = 1'b0;
    logic [3:0] cf;
    logic [31:0] q_rd[$], q_len[2][$];
    logic [1:0] q_pin[$];
    logic [31:0] rst_v[8] = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h88, 32'h0, 32'h0};
    logic [7:0] t_a[6] = '{OFF_A_DELAY, OFF_A_WIDTH, OFF_B_DELAY, OFF_B_WIDTH, 8'h1c, OFF_STATUS};
    logic [31:0] t_d[6] = '{32'h0, 32'hffffffff, 32'h000f4240, 32'h00000abc, 32'h5a5a5a5a, 32'hffffffff};
    logic [31:0] t_e[6] = '{32'h1, 32'h000f4240, 32'h000f4240, 32'h00000abc, 32'h0, 32'h0};
    int bad_count = 0, comparisons = 0;
    event rd_ev, pin_ev;

    spom_top uut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
        .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
        .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
        .I_EXPOSURE_BEGIN_EVENT(I_EXPOSURE_BEGIN_EVENT), .I_READOUT_BEGIN_EVENT(I_READOUT_BEGIN_EVENT),
        .I_TRIGGER(I_TRIGGER), .I_INTERNAL_PULSE_SOURCE(I_INTERNAL_PULSE_SOURCE),
        .O_OUTPUT_LINE_A(O_OUTPUT_LINE_A), .O_OUTPUT_LINE_B(O_OUTPUT_LINE_B));
    spom_lamp lamp_a (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_arm(lamp_arm), .i_active_high(1'b1),
        .i_line(O_OUTPUT_LINE_A), .o_done(done_a), .o_len(len_a));
    spom_lamp lamp_b (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_arm(lamp_arm), .i_active_high(1'b0),
        .i_line(O_OUTPUT_LINE_B), .o_done(done_b), .o_len(len_b));

    always #5 I_CLK = ~I_CLK;

    task automatic note(input bit ok, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (!ok) begin
            bad_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : note
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
        note(g === e, e, g);
    endtask : chk_rd
    task automatic chk_len(input logic [31:0] e, input logic [31:0] g);
        note(g === e, e, g);
    endtask : chk_len
    task automatic chk_pin(input logic [1:0] e, input logic [1:0] g);
        note(g === e, 32'(e), 32'(g));
    endtask : chk_pin
    task automatic chk_dly(input int d, input int n, input int lim);
        note(d == 0 ? n == lim : (n >= (d - 1) * TICK_CYCLES && n <= d * TICK_CYCLES + 3), 32'(d * TICK_CYCLES), 32'(n));
    endtask : chk_dly

    // Result watchers: each result takes the oldest expectation
    always @(rd_ev) chk_rd(q_rd.pop_front(), rd_got);
    always @(pin_ev) chk_pin(q_pin.pop_front(), {O_OUTPUT_LINE_A, O_OUTPUT_LINE_B});
    always @(posedge I_CLK) begin
        if (done_a === 1'b1) chk_len(q_len[0].pop_front(), len_a);
        if (done_b === 1'b1) chk_len(q_len[1].pop_front(), len_b);
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr
    function automatic logic mux(input logic [2:0] s, input logic [31:0] r, input logic l);
        logic v;
        v = (s == 3'h1) ? r[0] : (s == 3'h2) ? r[1] : 1'b0;
        return l ? v : !v;
    endfunction : mux

    // One Avalon-MM access, held until waitrequest is sampled low
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_AVS_ADDRESS <= a;
        I_AVS_WRITEDATA <= d;
        I_AVS_WRITE <= wr;
        I_AVS_READ <= !wr;
        do begin
            @(posedge I_CLK);
        end while (O_AVS_WAITREQUEST !== 1'b0);
        rd_got = O_AVS_READDATA;
        I_AVS_WRITE <= 1'b0;
        I_AVS_READ <= 1'b0;
        if (!wr) -> rd_ev;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic pin(input logic [1:0] e);
        repeat (2) @(posedge I_CLK);
        #1;
        q_pin.push_back(e);
        -> pin_ev;
    endtask : pin
    task automatic ev(input bit rdo);
        @(posedge I_CLK);
        if (rdo) I_READOUT_BEGIN_EVENT <= 1'b1;
        else I_EXPOSURE_BEGIN_EVENT <= 1'b1;
        @(posedge I_CLK);
        I_READOUT_BEGIN_EVENT <= 1'b0;
        I_EXPOSURE_BEGIN_EVENT <= 1'b0;
    endtask : ev
    // Event, then time to the line lighting; d of 0 means no flash may follow
    task automatic fire(input bit rdo, input bit b, input int d, input int w);
        int n;
        int lim;
        n = 0;
        lim = (d > 0) ? d * TICK_CYCLES + 10 : 4 * TICK_CYCLES;
        if (d > 0) q_len[b].push_back(32'(w * TICK_CYCLES));
        ev(rdo);
        while (((b ? !O_OUTPUT_LINE_B : O_OUTPUT_LINE_A) !== 1'b1) && n < lim) begin
            @(posedge I_CLK);
            n++;
        end
        chk_dly(d, n, lim);
        if (d > 0) repeat ((w + 1) * TICK_CYCLES) @(posedge I_CLK);
    endtask : fire

    task automatic close_out();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (40000) @(posedge I_CLK);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        @(posedge I_CLK);
        pin(2'b00);
        for (int i = 0; i < 8; i++) rd(8'(4 * i), rst_v[i]);
        for (int i = 0; i < 6; i++) begin
            wr(t_a[i], t_d[i]);
            rd(t_a[i], t_e[i]);
        end
        // Lane 0 alone merges into a setting; a control write without lane 0 is ignored
        I_AVS_BYTEENABLE <= 4'h1;
        wr(OFF_A_WIDTH, 32'h00000005);
        rd(OFF_A_WIDTH, 32'h000f4205);
        I_AVS_BYTEENABLE <= 4'h2;
        wr(OFF_CTRL, 32'h0000000f);
        rd(OFF_CTRL, 32'h0);
        I_AVS_BYTEENABLE <= 4'hf;
        // Every source and level on both lines, strobes switched off
        for (int c = 0; c < 16; c++) begin
            cf = 4'(c);
            wr(OFF_LINE_CFG, {24'h0, ~cf[3], cf[2:0], cf[3], cf[2:0]});
            repeat (2) begin
                @(posedge I_CLK);
                seed = lfsr(seed);
                I_TRIGGER <= seed[0];
                I_INTERNAL_PULSE_SOURCE <= seed[1];
                pin({mux(cf[2:0], seed, cf[3]), mux(cf[2:0], seed, ~cf[3])});
            end
        end
        wr(OFF_CTRL, 32'h1);
        wr(OFF_A_DELAY, 32'h3);
        wr(OFF_A_WIDTH, 32'h2);
        wr(OFF_B_DELAY, 32'h1);
        wr(OFF_B_WIDTH, 32'h2);
        wr(OFF_LINE_CFG, 32'h4b);
        pin(2'b01);
        lamp_arm <= 1'b1;
        fire(1'b0, 1'b0, 3, 2);
        fire(1'b1, 1'b0, 0, 0);
        ev(1'b0);
        repeat (140) @(posedge I_CLK);
        rd(OFF_STATUS, 32'h24);
        fire(1'b0, 1'b0, 3, 2);
        wr(OFF_CTRL, 32'h7);
        fire(1'b1, 1'b0, 3, 2);
        fire(1'b0, 1'b1, 1, 2);
        wr(OFF_CTRL, 32'hc);
        fire(1'b1, 1'b1, 1, 2);
        fire(1'b0, 1'b0, 0, 0);
        note(q_len[0].size() + q_len[1].size() == 0, 32'h0, 32'(q_len[0].size() + q_len[1].size()));
        close_out();
    end
endmodule : tb_strobe_pulse_output_mux
